// file: fsp_regs.svh
// Constants for the write latch and sector protection command logic
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_OP_WREN 8'h06
`define FSP_OP_WRDI 8'h04
`define FSP_OP_PROT 8'h36
`define FSP_OP_UNPROT 8'h39
`define FSP_NUM_SECT 32
`define FSP_SECT_LSB 16
`define FSP_SECT_W 5
`define FSP_PROT_RST 32'hFFFFFFFF
`define FSP_ADDR_BYTES 3'h3
`endif

// file: fsp_pkg.sv
// Types for the write latch and sector protection command logic
package fsp_pkg;
	typedef enum logic [2:0] {
		FSP_IDLE,
		FSP_ADDR,
		FSP_DONE,
		FSP_SKIP
	} fsp_state_type;
endpackage

// file: fsp_sector_protect.sv
// Serial command decoder for write latch and per-sector protection bits
// Contract
// - Complete 06h then chip-select rise on a byte boundary sets the write latch.
// - Complete 04h clears the write latch at chip-select rise.
// - Bytes after the write-disable opcode are ignored.
// - Modifying commands are refused while the write latch is clear.
// - Incomplete or misaligned write-enable/disable aborts and keeps the latch.
// - One protection bit per 64KB sector.
// - All protection bits reset to 1.
// - Bit 0 allows program and erase of the sector, 1 blocks both.
// - Protect is 36h plus three address bytes; later bytes ignored.
// - Valid protect sets the addressed sector bit and clears the latch.
// - Short or misaligned protect aborts, keeps the bit, clears the latch.
// - Protect under protection lock is ignored and clears the latch.
// - Unprotect is 39h plus three address bytes; later bytes ignored.
// - Valid unprotect clears the addressed sector bit and clears the latch.
// - Short or misaligned unprotect aborts, keeps the bit, clears the latch.
// - Unprotect under protection lock is ignored and clears the latch.
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_sector_protect (
	input wire logic CLK, // System clock, 250 MHz
	input wire logic RESET_N, // Asynchronous reset, active low
	input wire logic CS_N, // Serial chip select, active low
	input wire logic SCK, // Serial clock, sampled
	input wire logic SI, // Serial data in
	input wire logic PROT_LOCK, // Protection lock flag from status logic
	input wire logic [23:0] CHK_ADDR, // Address queried for program or erase
	output logic WRITE_LATCH, // Write latch flag
	output logic [`FSP_NUM_SECT-1:0] SECT_PROT, // Sector protection bits
	output logic CHK_ALLOWED // Program or erase allowed at CHK_ADDR
);
	fsp_pkg::fsp_state_type state_ff, nxt_state;
	logic sck_d_ff, cs_d_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] opcode_ff;
	logic [2:0] byte_cnt_ff;
	logic [23:0] addr_ff;
	logic wel_ff;
	logic [`FSP_NUM_SECT-1:0] prot_ff;

	function automatic logic [`FSP_SECT_W-1:0] sect_of(input logic [23:0] a);
		sect_of = a[`FSP_SECT_LSB +: `FSP_SECT_W];
	endfunction

	wire sck_rise = SCK & ~sck_d_ff & ~CS_N;
	wire [7:0] shifted = {shift_ff[6:0], SI};
	wire byte_done = sck_rise & (bit_cnt_ff == 3'h7);
	wire cs_end = CS_N & ~cs_d_ff;
	wire aligned = (bit_cnt_ff == 3'h0);
	wire is_prot = (opcode_ff == `FSP_OP_PROT);
	wire is_unprot = (opcode_ff == `FSP_OP_UNPROT);
	wire sect_cmd = is_prot | is_unprot;
	// Sector commands ending anywhere still clear the latch; only a complete one edits the bit
	wire sect_ok = sect_cmd & (state_ff == fsp_pkg::FSP_DONE) & aligned;
	wire sect_apply = cs_end & sect_ok & wel_ff & ~PROT_LOCK;
	wire [`FSP_SECT_W-1:0] tgt = sect_of(addr_ff);
	wire short_ok = cs_end & aligned & (state_ff == fsp_pkg::FSP_SKIP);
	wire do_wren = short_ok & (opcode_ff == `FSP_OP_WREN);
	wire do_wrdi = short_ok & (opcode_ff == `FSP_OP_WRDI);
	// The opcode register may be stale from an earlier frame; the state test rules that out
	wire sect_end = cs_end & sect_cmd & (state_ff != fsp_pkg::FSP_IDLE);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fsp_pkg::FSP_IDLE: begin
				if (byte_done) begin
					if (shifted == `FSP_OP_PROT || shifted == `FSP_OP_UNPROT) begin
						nxt_state = fsp_pkg::FSP_ADDR;
					end else begin
						nxt_state = fsp_pkg::FSP_SKIP;
					end
				end
			end
			fsp_pkg::FSP_ADDR: begin
				if (byte_done && byte_cnt_ff == `FSP_ADDR_BYTES - 3'h1) begin
					nxt_state = fsp_pkg::FSP_DONE;
				end
			end
			fsp_pkg::FSP_DONE: nxt_state = fsp_pkg::FSP_DONE;
			fsp_pkg::FSP_SKIP: nxt_state = fsp_pkg::FSP_SKIP;
			default: nxt_state = fsp_pkg::FSP_IDLE;
		endcase
		if (CS_N) begin
			nxt_state = fsp_pkg::FSP_IDLE;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sck_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
			state_ff <= fsp_pkg::FSP_IDLE;
		end else begin
			sck_d_ff <= SCK;
			cs_d_ff <= CS_N;
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			byte_cnt_ff <= 3'h0;
			opcode_ff <= 8'h00;
			addr_ff <= 24'h000000;
		end else if (CS_N) begin
			// Counters kept until idle so the end check sees the alignment
			if (cs_end) begin
				bit_cnt_ff <= 3'h0;
				byte_cnt_ff <= 3'h0;
			end
		end else if (sck_rise) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			shift_ff <= shifted;
			if (byte_done) begin
				if (state_ff == fsp_pkg::FSP_IDLE) begin
					opcode_ff <= shifted;
				end else if (state_ff == fsp_pkg::FSP_ADDR) begin
					addr_ff <= {addr_ff[15:0], shifted};
					byte_cnt_ff <= byte_cnt_ff + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wel_ff <= 1'b0;
		end else if (do_wren) begin
			wel_ff <= 1'b1;
		end else if (do_wrdi || sect_end) begin
			wel_ff <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `FSP_NUM_SECT; gi++) begin : g_sect
			always_ff @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					prot_ff[gi] <= 1'b1;
				end else if (sect_apply && int'(tgt) == gi) begin
					prot_ff[gi] <= is_prot;
				end
			end
		end
	endgenerate

	assign WRITE_LATCH = wel_ff;
	assign SECT_PROT = prot_ff;
	assign CHK_ALLOWED = wel_ff & ~prot_ff[sect_of(CHK_ADDR)];

	property p_wren;
		@(posedge CLK) disable iff (!RESET_N) do_wren |=> WRITE_LATCH;
	endproperty
	a_wren: assert property (p_wren) else $error("latch not set");
	property p_wrdi;
		@(posedge CLK) disable iff (!RESET_N) do_wrdi |=> !WRITE_LATCH;
	endproperty
	a_wrdi: assert property (p_wrdi) else $error("latch not cleared");
	property p_abort_keep;
		@(posedge CLK) disable iff (!RESET_N)
			(cs_end && !aligned && !sect_cmd) |=> $stable(WRITE_LATCH);
	endproperty
	a_abort_keep: assert property (p_abort_keep) else $error("latch moved");
	property p_locked;
		@(posedge CLK) disable iff (!RESET_N)
			(PROT_LOCK || !wel_ff) |=> $stable(SECT_PROT);
	endproperty
	a_locked: assert property (p_locked) else $error("locked bits changed");
	property p_prot;
		@(posedge CLK) disable iff (!RESET_N)
			(sect_apply && is_prot) |=> SECT_PROT[$past(tgt)] && !WRITE_LATCH;
	endproperty
	a_prot: assert property (p_prot) else $error("protect failed");
	property p_unprot;
		@(posedge CLK) disable iff (!RESET_N)
			(sect_apply && is_unprot) |=> !SECT_PROT[$past(tgt)] && !WRITE_LATCH;
	endproperty
	a_unprot: assert property (p_unprot) else $error("unprotect failed");
	property p_short;
		@(posedge CLK) disable iff (!RESET_N)
			(sect_end && !sect_ok) |=> $stable(SECT_PROT) && !WRITE_LATCH;
	endproperty
	a_short: assert property (p_short) else $error("short sector cmd");
	property p_allow;
		@(posedge CLK) disable iff (!RESET_N)
			CHK_ALLOWED |-> !SECT_PROT[CHK_ADDR[`FSP_SECT_LSB +: `FSP_SECT_W]];
	endproperty
	a_allow: assert property (p_allow) else $error("protected allowed");
	property p_wel_frame;
		@(posedge CLK) disable iff (!RESET_N)
			!cs_end |=> $stable(WRITE_LATCH);
	endproperty
	a_wel_frame: assert property (p_wel_frame) else $error("latch mid frame");
	property p_bits_apply;
		@(posedge CLK) disable iff (!RESET_N)
			!sect_apply |=> $stable(SECT_PROT);
	endproperty
	a_bits_apply: assert property (p_bits_apply) else $error("stray bit change");
	property p_lock_clear;
		@(posedge CLK) disable iff (!RESET_N)
			(sect_end && PROT_LOCK) |=> !WRITE_LATCH && $stable(SECT_PROT);
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("locked cmd acted");
	property p_idle;
		@(posedge CLK) disable iff (!RESET_N)
			CS_N |=> (state_ff == fsp_pkg::FSP_IDLE);
	endproperty
	a_idle: assert property (p_idle) else $error("not idle");
	property p_gate;
		@(posedge CLK) disable iff (!RESET_N)
			!WRITE_LATCH |-> !CHK_ALLOWED;
	endproperty
	a_gate: assert property (p_gate) else $error("gate open");
	c_wren: cover property (@(posedge CLK) do_wren);
	c_prot: cover property (@(posedge CLK) sect_apply && is_prot);
	c_unprot: cover property (@(posedge CLK) sect_apply && is_unprot);
	c_lock: cover property (@(posedge CLK) sect_end && PROT_LOCK);
	c_abort: cover property (@(posedge CLK) sect_end && !sect_ok);
endmodule

// file: fsp_host_model.sv
// Host serial controller model for the sector protection command logic
`timescale 1ns/1ps
module fsp_host_model (
	input wire logic clk, // System clock
	output logic cs_n, // Chip select, active low
	output logic sck, // Serial clock, idle level set per transfer by the idle argument
	output logic si // Serial data
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Each clock phase lasts two system cycles so the rise can be detected
	// Idle level 0 gives mode 0; idle level 1 gives mode 3, data changing on the fall
	task automatic xfer(input logic [39:0] d, input int n, input logic idle);
		@(posedge clk) #1 sck = idle;
		@(posedge clk) #1 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (idle) begin
				repeat (2) @(posedge clk);
				#1 sck = 1'b0;
			end
			si = d[39-i];
			repeat (2) @(posedge clk);
			#1 sck = 1'b1;
			if (!idle) begin
				repeat (2) @(posedge clk);
				#1 sck = 1'b0;
			end
		end
		repeat (2) @(posedge clk);
		#1 cs_n = 1'b1;
		// Released data line shows the inverse so a stale value cannot pass
		si = ~si;
		repeat (4) @(posedge clk);
	endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the write latch and sector protection logic
`timescale 1ns/1ps
`include "fsp_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
	logic clk, reset_n, cs_n, sck, si, prot_lock, write_latch, chk_allowed;
	logic [23:0] chk_addr;
	logic [`FSP_NUM_SECT-1:0] sect_prot;
	logic [`FSP_NUM_SECT-1:0] exp_prot = `FSP_PROT_RST;
	int failures = 0;
	int tests_run = 0;
	logic sck_idle = 1'b0;
	fsp_host_model u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
	fsp_sector_protect u_dut (.CLK(clk), .RESET_N(reset_n), .CS_N(cs_n), .SCK(sck),
		.SI(si), .PROT_LOCK(prot_lock), .CHK_ADDR(chk_addr), .WRITE_LATCH(write_latch),
		.SECT_PROT(sect_prot), .CHK_ALLOWED(chk_allowed));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop();
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] rest, input int n);
		u_host.xfer({op, rest}, n, sck_idle);
	endtask
	task automatic chk_state(input logic wl);
		`CHK("write_latch", wl, write_latch)
		`CHK("sect_prot", exp_prot, sect_prot)
	endtask
	task automatic chk_gate(input logic [23:0] a, input logic ok);
		@(posedge clk) #1 chk_addr = a;
		#1 `CHK("chk_allowed", ok, chk_allowed)
	endtask
	task automatic t_latch();
		chk_state(1'b0);
		chk_gate(24'h000000, 1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		chk_state(1'b1);
		cmd(`FSP_OP_WRDI, 32'hA5000000, 16);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_WRDI, 32'h0, 7);
		chk_state(1'b1);
		cmd(`FSP_OP_WRDI, 32'h0, 12);
		chk_state(1'b1);
	endtask
	task automatic t_unprot();
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_UNPROT, 32'h05123400, 32);
		exp_prot[5] = 1'b0;
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		chk_gate(24'h05FFFF, 1'b1);
		chk_gate(24'h060000, 1'b0);
		cmd(`FSP_OP_WRDI, 32'h0, 8);
		chk_gate(24'h050000, 1'b0);
		cmd(`FSP_OP_PROT, 32'h05000000, 32);
		chk_state(1'b0);
	endtask
	task automatic t_abort();
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_PROT, 32'h05000000, 20);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_PROT, 32'h05000000, 16);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_UNPROT, 32'h1F000000, 28);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_UNPROT, 32'h1F000000, 36);
		chk_state(1'b0);
	endtask
	task automatic t_prot_lock();
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_PROT, 32'h05ABCDEF, 40);
		exp_prot[5] = 1'b1;
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_UNPROT, 32'h07000000, 32);
		exp_prot[7] = 1'b0;
		chk_state(1'b0);
		@(posedge clk) #1 prot_lock = 1'b1;
		cmd(`FSP_OP_WREN, 32'h0, 8);
		chk_state(1'b1);
		cmd(`FSP_OP_PROT, 32'h07000000, 32);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		cmd(`FSP_OP_UNPROT, 32'h05000000, 32);
		chk_state(1'b0);
		@(posedge clk) #1 prot_lock = 1'b0;
	endtask
	task automatic t_mode3();
		sck_idle = 1'b1;
		cmd(`FSP_OP_WREN, 32'h0, 8);
		chk_state(1'b1);
		cmd(`FSP_OP_WRDI, 32'h0, 12);
		chk_state(1'b1);
		cmd(`FSP_OP_UNPROT, 32'h0A123456, 32);
		exp_prot[10] = 1'b0;
		chk_state(1'b0);
		sck_idle = 1'b0;
	endtask
	// Reset in mid-run must bring every sector back to protected
	task automatic t_reset();
		cmd(`FSP_OP_WREN, 32'h0, 8);
		@(posedge clk) #1 reset_n = 1'b0;
		exp_prot = `FSP_PROT_RST;
		repeat (2) @(posedge clk);
		#1 chk_state(1'b0);
		@(posedge clk) #1 reset_n = 1'b1;
		repeat (2) @(posedge clk);
		chk_state(1'b0);
		cmd(`FSP_OP_WREN, 32'h0, 8);
		chk_state(1'b1);
		chk_gate(24'h0A0000, 1'b0);
	endtask
	// Guards against a hung scenario
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		reset_n = 1'b0;
		prot_lock = 1'b0;
		chk_addr = 24'h000000;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		repeat (2) @(posedge clk);
		t_latch();
		t_unprot();
		t_abort();
		t_prot_lock();
		t_mode3();
		t_reset();
		report_and_stop();
	end
endmodule
